// File: ssb_bank.sv
// status and readout register bank with fifo byte port
//
// Contract
// - status byte clears on read, resets zero
// - bits 7,5,1,0: acc, aux, watermark, full
// - temperature two's complement, 1 K, 0=23C
// - fill level low byte at 0x24
// - fill bits 13..8 in 0x25 bits 5..0
// - fifo bytes via byte port 0x26
// - state code in internal status bits 4..0
// - bit 5 flags invalid axis remapping
// - bit 6 flags low rate feature fault
// - bit 7 flags tap rate fault
// - internal status read-only, resets zero
// - watermark judged against host level 0x46
`timescale 1ns/100ps

module ssb_bank (
   input  wire logic        mclk_i,
   input  wire logic        srst_i,
   // host register access
   input  wire logic        reg_rd_i,
   input  wire logic        reg_wr_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   output logic      [7:0]  reg_rdata_o,
   output logic             reg_rvalid_o,
   // sensor events and values
   input  wire logic        acc_drdy_i,
   input  wire logic        aux_drdy_i,
   input  wire logic [7:0]  die_temp_i,
   input  wire logic [4:0]  state_code_i,
   input  wire logic        remap_fault_i,
   input  wire logic        low_rate_feature_fault_i,
   input  wire logic        tap_rate_fault_i,
   input  wire logic [7:0]  feat_irq_i,
   input  wire logic [31:0] step_count_i,
   input  wire logic [7:0]  activity_i,
   // fifo fill side
   input  wire logic        fifo_push_i,
   input  wire logic [7:0]  fifo_wdata_i,
   output logic             fifo_ready_o
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0]  rdata_q;
   logic [7:0]  rdata_d;
   logic        rvalid_q;
   logic [7:0]  irq_q;
   logic [7:0]  irq_d;
   logic [7:0]  temp_q;
   logic [7:0]  istat_q;
   logic [7:0]  istat_d;
   logic [ssb_pkg::FILL_W-1:0] wtm_q;
   logic [ssb_pkg::FILL_W-1:0] wtm_d;
   logic [ssb_pkg::FILL_W-1:0] fill_q;
   logic [ssb_pkg::FILL_W-1:0] fill_d;
   logic [ssb_pkg::FIFO_AW-1:0] wptr_q;
   logic [ssb_pkg::FIFO_AW-1:0] rptr_q;
   logic        wtm_hit_q;
   logic        full_q;
   logic [7:0]  mem [ssb_pkg::FIFO_DEPTH];

   // ------------------------------------------------------------
   // access decode
   // ------------------------------------------------------------
   wire rd_irq   = reg_rd_i &&
                   (reg_addr_i == ssb_pkg::ADDR_IRQ_BASIC);
   wire rd_port  = reg_rd_i &&
                   (reg_addr_i == ssb_pkg::ADDR_FIFO_PORT);
   wire wr_wtm_l = reg_wr_i &&
                   (reg_addr_i == ssb_pkg::ADDR_WTM_LOW);
   wire wr_wtm_h = reg_wr_i &&
                   (reg_addr_i == ssb_pkg::ADDR_WTM_HIGH);

   // ------------------------------------------------------------
   // fifo occupancy
   // ------------------------------------------------------------
   // count constants sized to the fill counter
   localparam logic [ssb_pkg::FILL_W-1:0] DEPTH_CNT =
      ssb_pkg::FILL_W'(ssb_pkg::FIFO_DEPTH);
   localparam logic [ssb_pkg::FILL_W-1:0] ONE_CNT =
      ssb_pkg::FILL_W'(1);

   wire fifo_empty = (fill_q == '0);
   wire fifo_full  = (fill_q == DEPTH_CNT);
   wire do_push    = fifo_push_i && !fifo_full;
   wire do_pop     = rd_port && !fifo_empty;

   // push refused while the store is full
   assign fifo_ready_o = !fifo_full;

   // count tracks unread bytes exactly
   always_comb begin
      fill_d = fill_q;
      if (do_push && !do_pop) begin
         fill_d = fill_q + ONE_CNT;
      end else if (do_pop && !do_push) begin
         fill_d = fill_q - ONE_CNT;
      end
   end

   // ------------------------------------------------------------
   // watermark and full conditions
   // ------------------------------------------------------------
   // zero level disables the watermark
   wire wtm_hit_d = (wtm_q != '0) && (fill_d >= wtm_q);
   wire full_d    = (fill_d == DEPTH_CNT);

   // flags fire on the rising edge of each condition
   wire fwm_evt   = wtm_hit_d && !wtm_hit_q;
   wire ffull_evt = full_d && !full_q;

   // ------------------------------------------------------------
   // interrupt status flags
   // ------------------------------------------------------------
   logic [ssb_pkg::IRQ_NUM-1:0] irq_set;
   localparam int IRQ_POS [ssb_pkg::IRQ_NUM] = '{
      ssb_pkg::IRQ_ACC_DRDY_BIT,
      ssb_pkg::IRQ_AUX_DRDY_BIT,
      ssb_pkg::IRQ_FWM_BIT,
      ssb_pkg::IRQ_FFULL_BIT
   };

   assign irq_set = {acc_drdy_i, aux_drdy_i, fwm_evt, ffull_evt};

   // per flag: set beats the read clear
   genvar gi;
   generate
      for (gi = 0; gi < ssb_pkg::IRQ_NUM; gi++) begin : g_irq
         assign irq_d[IRQ_POS[gi]] =
            irq_set[ssb_pkg::IRQ_NUM-1-gi] ||
            (irq_q[IRQ_POS[gi]] && !rd_irq);
      end
   endgenerate

   // reserved status bits stay zero
   assign irq_d[6] = 1'b0;
   assign irq_d[4] = 1'b0;
   assign irq_d[3] = 1'b0;
   assign irq_d[2] = 1'b0;

   // ------------------------------------------------------------
   // internal status assembly
   // ------------------------------------------------------------
   always_comb begin
      istat_d = ssb_pkg::RST_BYTE;
      istat_d[ssb_pkg::STATE_CODE_W-1:0] = state_code_i;
      istat_d[ssb_pkg::REMAP_ERR_BIT]    = remap_fault_i;
      istat_d[ssb_pkg::LOW_RATE_ERR_BIT] =
         low_rate_feature_fault_i;
      istat_d[ssb_pkg::TAP_RATE_ERR_BIT] =
         tap_rate_fault_i;
   end

   // ------------------------------------------------------------
   // watermark level, host writable
   // ------------------------------------------------------------
   always_comb begin
      wtm_d = wtm_q;
      if (wr_wtm_l) begin
         wtm_d[7:0] = reg_wdata_i;
      end
      if (wr_wtm_h) begin
         wtm_d[ssb_pkg::FILL_W-1:8] =
            reg_wdata_i[ssb_pkg::FILL_HIGH_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // read data selection
   // ------------------------------------------------------------
   wire [7:0] fill_low  = fill_q[7:0];
   wire [7:0] fill_high = {2'b00,
                           fill_q[ssb_pkg::FILL_W-1:8]};
   wire [7:0] wtm_high  = {2'b00,
                           wtm_q[ssb_pkg::FILL_W-1:8]};
   wire [7:0] port_byte = fifo_empty ? ssb_pkg::EMPTY_READ
                                     : mem[rptr_q];

   // step count split into bytes, least significant first
   logic [7:0] step_byte [4];
   genvar gs;
   generate
      for (gs = 0; gs < 4; gs++) begin : g_step
         assign step_byte[gs] = step_count_i[8*gs +: 8];
      end
   endgenerate

   // offset picks the byte returned by a read
   always_comb begin
      unique case (reg_addr_i)
         ssb_pkg::ADDR_FEAT_IRQ:  rdata_d = feat_irq_i;
         ssb_pkg::ADDR_IRQ_BASIC: rdata_d = irq_q;
         ssb_pkg::ADDR_STEP_B0:   rdata_d = step_byte[0];
         ssb_pkg::ADDR_STEP_B1:   rdata_d = step_byte[1];
         ssb_pkg::ADDR_STEP_B2:   rdata_d = step_byte[2];
         ssb_pkg::ADDR_STEP_B3:   rdata_d = step_byte[3];
         ssb_pkg::ADDR_DIE_TEMP:  rdata_d = temp_q;
         ssb_pkg::ADDR_FILL_LOW:  rdata_d = fill_low;
         ssb_pkg::ADDR_FILL_HIGH: rdata_d = fill_high;
         ssb_pkg::ADDR_FIFO_PORT: rdata_d = port_byte;
         ssb_pkg::ADDR_ACTIVITY:  rdata_d = activity_i;
         ssb_pkg::ADDR_INT_STATE: rdata_d = istat_q;
         ssb_pkg::ADDR_WTM_LOW:   rdata_d = wtm_q[7:0];
         ssb_pkg::ADDR_WTM_HIGH:  rdata_d = wtm_high;
         default:                 rdata_d = ssb_pkg::UNMAPPED_READ;
      endcase
   end

   // ------------------------------------------------------------
   // fifo storage write
   // ------------------------------------------------------------
   // store has no reset; the count guards stale bytes
   always_ff @(posedge mclk_i) begin
      if (do_push) begin
         mem[wptr_q] <= fifo_wdata_i;
      end
   end

   // ------------------------------------------------------------
   // fifo pointers and count
   // ------------------------------------------------------------
   // write pointer advances on each accepted push
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         wptr_q <= '0;
      end else begin
         wptr_q <= wptr_q + ssb_pkg::FIFO_AW'(do_push);
      end
   end

   // read pointer advances on each port pop
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         rptr_q <= '0;
      end else begin
         rptr_q <= rptr_q + ssb_pkg::FIFO_AW'(do_pop);
      end
   end

   // byte count, the only guard against stale store entries
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         fill_q <= '0;
      end else begin
         fill_q <= fill_d;
      end
   end

   // ------------------------------------------------------------
   // condition history for edge detection
   // ------------------------------------------------------------
   // watermark condition of the previous cycle
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         wtm_hit_q <= 1'b0;
      end else begin
         wtm_hit_q <= wtm_hit_d;
      end
   end

   // full condition of the previous cycle
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         full_q <= 1'b0;
      end else begin
         full_q <= full_d;
      end
   end

   // ------------------------------------------------------------
   // status registers
   // ------------------------------------------------------------
   // interrupt status flags
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         irq_q <= ssb_pkg::RST_BYTE;
      end else begin
         irq_q <= irq_d;
      end
   end

   // internal status copy, read-only to the host
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         istat_q <= ssb_pkg::RST_BYTE;
      end else begin
         istat_q <= istat_d;
      end
   end

   // die temperature copy
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         temp_q <= ssb_pkg::RST_BYTE;
      end else begin
         temp_q <= die_temp_i;
      end
   end

   // ------------------------------------------------------------
   // watermark register
   // ------------------------------------------------------------
   // level resets to zero, so the watermark starts disabled
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         wtm_q <= '0;
      end else begin
         wtm_q <= wtm_d;
      end
   end

   // ------------------------------------------------------------
   // read answer, one cycle after the strobe
   // ------------------------------------------------------------
   // answer strobe follows each read strobe
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= reg_rd_i;
      end
   end

   // read data holds until the next read
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         rdata_q <= ssb_pkg::RST_BYTE;
      end else if (reg_rd_i) begin
         rdata_q <= rdata_d;
      end
   end

   // read outputs straight from flip-flops
   assign reg_rdata_o  = rdata_q;
   assign reg_rvalid_o = rvalid_q;

endmodule : ssb_bank

// File: ssb_pkg.sv
// constants of the sensor status and readout register bank
package ssb_pkg;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_FEAT_IRQ   = 8'h1C;
   localparam logic [7:0] ADDR_IRQ_BASIC  = 8'h1D;
   localparam logic [7:0] ADDR_STEP_B0    = 8'h1E;
   localparam logic [7:0] ADDR_STEP_B1    = 8'h1F;
   localparam logic [7:0] ADDR_STEP_B2    = 8'h20;
   localparam logic [7:0] ADDR_STEP_B3    = 8'h21;
   localparam logic [7:0] ADDR_DIE_TEMP   = 8'h22;
   localparam logic [7:0] ADDR_FILL_LOW   = 8'h24;
   localparam logic [7:0] ADDR_FILL_HIGH  = 8'h25;
   localparam logic [7:0] ADDR_FIFO_PORT  = 8'h26;
   localparam logic [7:0] ADDR_ACTIVITY   = 8'h27;
   localparam logic [7:0] ADDR_INT_STATE  = 8'h2A;
   localparam logic [7:0] ADDR_WTM_LOW    = 8'h46;
   localparam logic [7:0] ADDR_WTM_HIGH   = 8'h47;

   // ------------------------------------------------------------
   // field positions and widths
   // ------------------------------------------------------------
   localparam int IRQ_ACC_DRDY_BIT = 7;
   localparam int IRQ_AUX_DRDY_BIT = 5;
   localparam int IRQ_FWM_BIT      = 1;
   localparam int IRQ_FFULL_BIT    = 0;
   localparam int IRQ_NUM          = 4;
   localparam int REMAP_ERR_BIT    = 5;
   localparam int LOW_RATE_ERR_BIT = 6;
   localparam int TAP_RATE_ERR_BIT = 7;
   localparam int STATE_CODE_W     = 5;
   localparam int FILL_W           = 14;
   localparam int FILL_HIGH_W      = 6;

   // ------------------------------------------------------------
   // reset values and codes
   // ------------------------------------------------------------
   localparam logic [7:0] RST_BYTE       = 8'h00;
   localparam logic [7:0] UNMAPPED_READ  = 8'h00;
   localparam logic [7:0] EMPTY_READ     = 8'h00;
   localparam logic [4:0] ST_NOT_INIT    = 5'h00;
   localparam logic [4:0] ST_INIT_OK     = 5'h01;
   localparam logic [4:0] ST_INIT_ERR    = 5'h02;
   localparam logic [4:0] ST_DRV_ERR     = 5'h03;
   localparam logic [4:0] ST_SNS_STOP    = 5'h04;
   // temperature reading of zero stands for this many degrees C
   localparam int TEMP_ZERO_DEG_C = 23;

   // ------------------------------------------------------------
   // fifo storage
   // ------------------------------------------------------------
   localparam int FIFO_DEPTH = 1024;
   localparam int FIFO_AW    = 10;

endpackage : ssb_pkg

// File: ssb_bank_checker.sv
// concurrent checks on the register bank ports
`timescale 1ns/100ps

module ssb_checker (
   input  wire logic       mclk_i,
   input  wire logic       srst_i,
   input  wire logic       reg_rd_i,
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_rdata_o,
   input  wire logic       reg_rvalid_o,
   input  wire logic       acc_drdy_i,
   input  wire logic       aux_drdy_i,
   input  wire logic [7:0] die_temp_i,
   input  wire logic [4:0] state_code_i,
   input  wire logic       remap_fault_i,
   input  wire logic       low_rate_feature_fault_i,
   input  wire logic       tap_rate_fault_i
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (srst_i);

   // one read request at a given offset
   sequence s_rd(a);
      reg_rd_i && reg_addr_i == a;
   endsequence

   chk_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
      else $error("no read answer one cycle after request");
   chk_no_stray_valid: assert property (!reg_rd_i |=> !reg_rvalid_o)
      else $error("read answer without request");
   chk_fill_high_zero: assert property (s_rd(8'h25) |=>
      reg_rdata_o[7:6] == 2'b00) else $error("fill high top bits set");
   chk_irq_reserved: assert property (s_rd(8'h1D) |=>
      !reg_rdata_o[6] && reg_rdata_o[4:2] == 3'b000)
      else $error("status reserved bits set");
   chk_irq_clear_read: assert property ((s_rd(8'h1D) ##0
      !acc_drdy_i && !aux_drdy_i) ##1 s_rd(8'h1D) |=>
      !reg_rdata_o[7] && !reg_rdata_o[5]) else $error("flags kept after read");
   chk_acc_flag_set: assert property (acc_drdy_i ##1 !reg_rd_i
      ##1 s_rd(8'h1D) |=> reg_rdata_o[7]) else $error("data ready lost");
   chk_temp_copy: assert property (reg_rd_i && reg_addr_i == 8'h22
      && !$past(srst_i) |=> reg_rdata_o == $past(die_temp_i, 2))
      else $error("temperature read wrong");
   chk_state_copy: assert property (
      reg_rd_i && reg_addr_i == 8'h2A
      && !$past(srst_i) |=> reg_rdata_o == {$past(tap_rate_fault_i, 2),
      $past(low_rate_feature_fault_i, 2), $past(remap_fault_i, 2),
      $past(state_code_i, 2)}) else $error("internal status read wrong");
endmodule : ssb_checker

bind ssb_bank ssb_checker i_chk (.mclk_i(mclk_i), .srst_i(srst_i),
   .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o),
   .reg_rvalid_o(reg_rvalid_o), .acc_drdy_i(acc_drdy_i),
   .aux_drdy_i(aux_drdy_i), .die_temp_i(die_temp_i),
   .state_code_i(state_code_i), .remap_fault_i(remap_fault_i),
   .low_rate_feature_fault_i(low_rate_feature_fault_i),
   .tap_rate_fault_i(tap_rate_fault_i));

// File: ssb_bank_host.sv
// host model issuing register reads and writes
`timescale 1ns/100ps

module ssb_host (
   input  wire logic       mclk_i,
   input  wire logic [7:0] rdata_i,
   input  wire logic       rvalid_i,
   output logic            rd_o,
   output logic            wr_o,
   output logic      [7:0] addr_o,
   output logic      [7:0] wdata_o
);
   logic [7:0] rbuf [8];
   logic       vld_ok;

   initial begin
      rd_o = 1'b0;
      wr_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
      vld_ok = 1'b1;
   end

   // burst of n reads at one offset, address scrambled when idle
   task rd(input logic [7:0] a, input int n);
      @(negedge mclk_i);
      rd_o = 1'b1;
      addr_o = a;
      for (int i = 0; i < n; i++) begin
         @(negedge mclk_i);
         if (i == n - 1) begin
            rd_o = 1'b0;
            addr_o = ~a;
         end
         if (rvalid_i !== 1'b1) vld_ok = 1'b0;
         rbuf[i] = rdata_i;
      end
   endtask : rd

   // single byte write
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk_i);
      wr_o = 1'b1;
      addr_o = a;
      wdata_o = d;
      @(negedge mclk_i);
      wr_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask : wr
endmodule : ssb_host

// File: ssb_bank_test.sv
// self-checking bench of the register bank
`timescale 1ns/100ps

module ssb_bank_test;
   logic       mclk, srst, rd, wr, acc, aux, remap, lowr, tapr, push, ready;
   logic       rvalid;
   logic [7:0] addr, wdata, rdata, temp, wdat;
   logic [4:0] st;
   int         err_total, n_compared;

   ssb_bank i_dut (.mclk_i(mclk), .srst_i(srst), .reg_rd_i(rd),
      .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .acc_drdy_i(acc),
      .aux_drdy_i(aux), .die_temp_i(temp), .state_code_i(st),
      .remap_fault_i(remap), .low_rate_feature_fault_i(lowr),
      .tap_rate_fault_i(tapr), .feat_irq_i(8'h00), .step_count_i(32'h0),
      .activity_i(8'h00), .fifo_push_i(push), .fifo_wdata_i(wdat),
      .fifo_ready_o(ready));
   ssb_host i_host (.mclk_i(mclk), .rdata_i(rdata), .rvalid_i(rvalid),
      .rd_o(rd), .wr_o(wr), .addr_o(addr), .wdata_o(wdata));

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task conclude;
      if (err_total == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : conclude

   task rst;
      {acc, aux, remap, lowr, tapr, push, st, temp, wdat} = '0;
      srst = 1'b1;
      repeat (10) @(negedge mclk);
      srst = 1'b0;
   endtask : rst

   task push_byte(input logic [7:0] d);
      @(negedge mclk);
      push = 1'b1;
      wdat = d;
      @(negedge mclk);
      push = 1'b0;
   endtask : push_byte

   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task t_reset;
      logic [7:0] regs [8];
      regs = '{8'h1D, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h2A, 8'h1C};
      foreach (regs[i]) begin
         i_host.rd(regs[i], 1);
         chk(i_host.rbuf[0], 8'h00);
      end
      chk({7'h00, ready}, 8'h01);
   endtask : t_reset

   task t_status;
      for (int c = 0; c < 5; c++) begin
         st = 5'(c);
         {tapr, lowr, remap} = 3'(c);
         temp = 8'hE9 + 8'(c);
         i_host.wr(8'h2A, 8'hFF);
         i_host.rd(8'h2A, 1);
         chk(i_host.rbuf[0], {3'(c), 5'(c)});
         i_host.rd(8'h22, 1);
         chk(i_host.rbuf[0], 8'hE9 + 8'(c));
      end
   endtask : t_status

   task t_irq;
      @(negedge mclk);
      {acc, aux} = 2'b11;
      @(negedge mclk);
      {acc, aux} = 2'b00;
      i_host.rd(8'h1D, 2);
      chk(i_host.rbuf[0], 8'hA0);
      chk(i_host.rbuf[1], 8'h00);
   endtask : t_irq

   task t_fifo;
      i_host.wr(8'h46, 8'h03);
      i_host.rd(8'h46, 1);
      chk(i_host.rbuf[0], 8'h03);
      for (int k = 0; k < 4; k++) push_byte(8'h30 + 8'(k));
      i_host.rd(8'h24, 1);
      chk(i_host.rbuf[0], 8'h04);
      i_host.rd(8'h1D, 1);
      chk(i_host.rbuf[0], 8'h02);
      i_host.rd(8'h26, 5);
      for (int k = 0; k < 4; k++) chk(i_host.rbuf[k], 8'h30 + 8'(k));
      chk(i_host.rbuf[4], 8'h00);
      i_host.rd(8'h24, 1);
      chk(i_host.rbuf[0], 8'h00);
      // one push beyond full is dropped
      for (int k = 0; k < 1025; k++) push_byte(8'(k));
      chk({7'h00, ready}, 8'h00);
      i_host.rd(8'h25, 1);
      chk(i_host.rbuf[0], 8'h04);
      i_host.rd(8'h24, 1);
      chk(i_host.rbuf[0], 8'h00);
      i_host.rd(8'h1D, 1);
      chk(i_host.rbuf[0], 8'h03);
   endtask : t_fifo

   // -------------------------------------------------------------
   // clock, watchdog and main sequence
   // -------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   initial begin
      repeat (20000) @(posedge mclk);
      err_total++;
      conclude;
   end

   initial begin
      err_total = 0;
      n_compared = 0;
      rst;
      t_reset;
      t_status;
      t_irq;
      t_fifo;
      rst;
      t_reset;
      chk({7'h00, i_host.vld_ok}, 8'h01);
      conclude;
   end
endmodule : ssb_bank_test
